// ==== rtl/chbfir_coef_bank.sv ====
// Behaviour
// - outer taps are signed 12-bit at 11:0; bits 15:12 reserved, reset zero.
// - readback always shows the coefficient field's top bit as zero.
// - channel-B taps drive the filter only in dual channel mode.
// - tap-three register supplies the third channel-B tap from bits 11:0.
// - register 0x44e supplies the fourth tap, resets to zero.
// - register 0x450 is 24 bits, coefficient 17:0, bits 23:18 reserved.
// - fifth tap is the centre tap, held at 18-bit resolution.
// - register 0x453 supplies the sixth tap, 12-bit, resets to zero.
// - register 0x455 supplies the seventh tap, 12-bit, resets to zero.
// - register 0x457 exists; reserved and field bits reset to zero.
// - register 0x457 supplies the eighth tap in dual channel mode.
`timescale 1ns/100ps
`default_nettype none
module chbfir_coef_bank (
   // clock and reset
   input  wire logic                              clk,
   input  wire logic                              sys_rst,
   // register port
   input  wire logic [chbfir_pkg::ADDR_W-1:0]     reg_addr,
   input  wire logic [chbfir_pkg::DATA_W-1:0]     reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   output logic      [chbfir_pkg::DATA_W-1:0]     reg_rdata,
   // mode from the device
   input  wire logic                              dual_channel_mode,
   // coefficients towards the channel-B filter
   output logic signed [chbfir_pkg::OUTER_COEF_W-1:0]  tap3_coef,
   output logic signed [chbfir_pkg::OUTER_COEF_W-1:0]  tap4_coef,
   output logic signed [chbfir_pkg::CENTER_COEF_W-1:0] center_tap_coef,
   output logic signed [chbfir_pkg::OUTER_COEF_W-1:0]  tap6_coef,
   output logic signed [chbfir_pkg::OUTER_COEF_W-1:0]  tap7_coef,
   output logic signed [chbfir_pkg::OUTER_COEF_W-1:0]  tap8_coef,
   output logic                                   chb_coef_active
);

   logic [chbfir_pkg::OUTER_W-1:0]  outer_reg [chbfir_pkg::NUM_OUTER];
   logic [chbfir_pkg::CENTER_W-1:0] center_reg;
   logic [2:0]                      wr_slot;
   logic [2:0]                      rd_slot;
   logic [chbfir_pkg::DATA_W-1:0]   next_rdata;
   logic                            dual_q;

   // address decode shared by write and read
   function automatic logic [2:0] slot_of(input logic [chbfir_pkg::ADDR_W-1:0] a);
      case (a)
         chbfir_pkg::OFF_TAP3:   slot_of = 3'(chbfir_pkg::SLOT_TAP3);
         chbfir_pkg::OFF_TAP4:   slot_of = 3'(chbfir_pkg::SLOT_TAP4);
         chbfir_pkg::OFF_CENTER: slot_of = chbfir_pkg::SLOT_CENTER;
         chbfir_pkg::OFF_TAP6:   slot_of = 3'(chbfir_pkg::SLOT_TAP6);
         chbfir_pkg::OFF_TAP7:   slot_of = 3'(chbfir_pkg::SLOT_TAP7);
         chbfir_pkg::OFF_TAP8:   slot_of = 3'(chbfir_pkg::SLOT_TAP8);
         default:                slot_of = chbfir_pkg::SLOT_NONE;
      endcase
   endfunction

   assign wr_slot = slot_of(reg_addr);
   assign rd_slot = slot_of(reg_addr);

   // outer taps; reserved bits are stored as written
   genvar g;
   generate
      for (g = 0; g < chbfir_pkg::NUM_OUTER; g++) begin : g_outer
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               outer_reg[g] <= chbfir_pkg::OUTER_RESET;
            end else if (reg_wr && wr_slot == 3'(g)) begin
               outer_reg[g] <= reg_wdata[chbfir_pkg::OUTER_W-1:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         center_reg <= chbfir_pkg::CENTER_RESET;
      end else if (reg_wr && wr_slot == chbfir_pkg::SLOT_CENTER) begin
         center_reg <= reg_wdata;
      end
   end

   // readback hides the field's sign bit
   always_comb begin
      next_rdata = chbfir_pkg::RDATA_ZERO;
      if (rd_slot == chbfir_pkg::SLOT_CENTER) begin
         next_rdata = center_reg;
         next_rdata[chbfir_pkg::CENTER_MSB] = 1'b0;
      end else if (rd_slot != chbfir_pkg::SLOT_NONE) begin
         next_rdata[chbfir_pkg::OUTER_W-1:0] = outer_reg[rd_slot];
         next_rdata[chbfir_pkg::OUTER_MSB] = 1'b0;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= chbfir_pkg::RDATA_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= chbfir_pkg::RDATA_ZERO;
      end
   end

   // outside dual channel mode the filter sees zeros from this bank
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dual_q <= 1'b0;
      end else begin
         dual_q <= dual_channel_mode;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tap3_coef       <= '0;
         tap4_coef       <= '0;
         center_tap_coef <= '0;
         tap6_coef       <= '0;
         tap7_coef       <= '0;
         tap8_coef       <= '0;
         chb_coef_active <= 1'b0;
      end else begin
         chb_coef_active <= dual_q;
         if (dual_q) begin
            tap3_coef       <= outer_reg[chbfir_pkg::SLOT_TAP3][chbfir_pkg::OUTER_MSB:0];
            tap4_coef       <= outer_reg[chbfir_pkg::SLOT_TAP4][chbfir_pkg::OUTER_MSB:0];
            center_tap_coef <= center_reg[chbfir_pkg::CENTER_MSB:0];
            tap6_coef       <= outer_reg[chbfir_pkg::SLOT_TAP6][chbfir_pkg::OUTER_MSB:0];
            tap7_coef       <= outer_reg[chbfir_pkg::SLOT_TAP7][chbfir_pkg::OUTER_MSB:0];
            tap8_coef       <= outer_reg[chbfir_pkg::SLOT_TAP8][chbfir_pkg::OUTER_MSB:0];
         end else begin
            tap3_coef       <= '0;
            tap4_coef       <= '0;
            center_tap_coef <= '0;
            tap6_coef       <= '0;
            tap7_coef       <= '0;
            tap8_coef       <= '0;
         end
      end
   end

endmodule // chbfir_coef_bank
`default_nettype wire

// ==== rtl/chbfir_pkg.sv ====
`default_nettype none
package chbfir_pkg;
   // register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 24;
   localparam int OUTER_W = 16;
   localparam int CENTER_W = 24;
   localparam int OUTER_COEF_W = 12;
   localparam int CENTER_COEF_W = 18;
   localparam int OUTER_MSB = 11;
   localparam int CENTER_MSB = 17;
   localparam int NUM_OUTER = 5;
   // register offsets (byte addresses of the register map)
   localparam logic [11:0] OFF_TAP3 = 12'h44c;
   localparam logic [11:0] OFF_TAP4 = 12'h44e;
   localparam logic [11:0] OFF_CENTER = 12'h450;
   localparam logic [11:0] OFF_TAP6 = 12'h453;
   localparam logic [11:0] OFF_TAP7 = 12'h455;
   localparam logic [11:0] OFF_TAP8 = 12'h457;
   // reset values
   localparam logic [15:0] OUTER_RESET = 16'h0000;
   localparam logic [23:0] CENTER_RESET = 24'h000000;
   localparam logic [23:0] RDATA_ZERO = 24'h000000;
   // tap slot indices: outer taps, then the centre and no-match slot codes
   localparam int SLOT_TAP3 = 0;
   localparam int SLOT_TAP4 = 1;
   localparam int SLOT_TAP6 = 2;
   localparam int SLOT_TAP7 = 3;
   localparam int SLOT_TAP8 = 4;
   localparam logic [2:0] SLOT_NONE = 3'h7;
   localparam logic [2:0] SLOT_CENTER = 3'h5;
endpackage
`default_nettype wire

// ==== testbench/chbfir_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module chbfir_props (
   // clock and reset
   input wire logic               clk,
   input wire logic               sys_rst,
   // register port
   input wire logic        [11:0] reg_addr,
   input wire logic        [23:0] reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic        [23:0] reg_rdata,
   // mode and coefficients
   input wire logic               dual_channel_mode,
   input wire logic               chb_coef_active,
   input wire logic signed [11:0] tap4_coef,
   input wire logic signed [11:0] tap8_coef,
   input wire logic signed [17:0] center_tap_coef
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // mode settled first, so the two-edge tap latency is the only delay
   sequence s_wr(a);
      dual_channel_mode[*3] ##0 reg_wr && reg_addr == a ##1 dual_channel_mode && !reg_wr;
   endsequence
   AST_TAP4: assert property (s_wr(12'h44e) |=> tap4_coef == $past(reg_wdata[11:0], 2))
      else $error("tap4 output wrong");
   AST_TAP8: assert property (s_wr(12'h457) |=> tap8_coef == $past(reg_wdata[11:0], 2))
      else $error("tap8 output wrong");
   AST_CTR: assert property (s_wr(12'h450) |=> center_tap_coef == $past(reg_wdata[17:0], 2))
      else $error("centre output wrong");
   // sampled reset in the window: the edge that releases reset still resets the design
   AST_OFF: assert property ((!sys_rst && !dual_channel_mode)[*3] |-> !chb_coef_active && tap8_coef == 12'h000 && tap4_coef == 12'h000 && center_tap_coef == 18'h00000)
      else $error("bank active outside dual mode");
   AST_ON: assert property ((!sys_rst && dual_channel_mode)[*3] |-> chb_coef_active)
      else $error("bank idle in dual mode");
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 0)
      else $error("read data without read");
   AST_OUT_MSB: assert property (reg_rd && reg_addr != 12'h450 |=> !reg_rdata[11] && reg_rdata[23:16] == 0)
      else $error("outer readback bits wrong");
   AST_CTR_MSB: assert property (reg_rd && reg_addr == 12'h450 |=> !reg_rdata[17])
      else $error("centre readback msb set");
endmodule // chbfir_props
bind chbfir_coef_bank chbfir_props chbfir_props_i (.clk, .sys_rst, .reg_wr, .reg_rd,
   .dual_channel_mode, .chb_coef_active, .reg_addr, .reg_wdata, .reg_rdata, .tap4_coef,
   .tap8_coef, .center_tap_coef);
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, dual_channel_mode = 1, act;
   logic [11:0] reg_addr = 0, ad [6] = '{12'h44c, 12'h44e, 12'h450, 12'h453, 12'h455, 12'h457};
   logic [23:0] reg_wdata = 0, reg_rdata, d;
   logic signed [11:0] t3, t4, t6, t7, t8;
   logic signed [17:0] tc;
   int n_errors = 0, compares = 0;
   always #5 clk = ~clk;
   chbfir_coef_bank chbfir_coef_bank_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .dual_channel_mode, .tap3_coef(t3), .tap4_coef(t4),
      .center_tap_coef(tc), .tap6_coef(t6), .tap7_coef(t7), .tap8_coef(t8), .chb_coef_active(act));
   task automatic chk(input logic [23:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // strobe dropped then one idle edge, so no signal is assigned twice in a step
   task automatic wr(input logic [11:0] a, input logic [23:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1;
      @(posedge clk);
      reg_wr <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [23:0] e);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, e);
      @(posedge clk);
   endtask
   task automatic complete_run;
      if (n_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) rd(ad[i], 0);
      for (int i = 0; i < 6; i++) begin
         d = (i == 2) ? 24'hfeedcb : 24'h00f800 + 24'h000111 * i;
         wr(ad[i], d);
         rd(ad[i], d & ((i == 2) ? 24'hfdffff : 24'hfff7ff));
      end
      chk({23'h0, act}, 24'h1);
      chk({12'h0, t3}, 24'h800);
      chk({12'h0, t4}, 24'h911);
      chk({6'h0, tc}, 24'h2edcb);
      chk({12'h0, t6}, 24'hb33);
      chk({12'h0, t7}, 24'hc44);
      chk({12'h0, t8}, 24'hd55);
      wr(12'h451, 24'hffffff);
      rd(12'h451, 24'h0);
      rd(12'h450, 24'hfcedcb);
      dual_channel_mode <= 0;
      repeat (3) @(posedge clk);
      #1 chk({act, t4}, 24'h0);
      chk({t3, t6}, 24'h0);
      chk({t7, t8}, 24'h0);
      chk({6'h0, tc}, 24'h0);
      rd(12'h44e, 24'h00f111);
      dual_channel_mode <= 1;
      repeat (3) @(posedge clk);
      #1 chk({act, t8}, 24'h1d55);
      // mid-run reset must clear written fields and reserved bits alike
      sys_rst <= 1;
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) rd(ad[i], 0);
      #1 chk({act, t8}, 24'h1000);
      chk({6'h0, tc}, 24'h0);
      chk({t3, t4}, 24'h0);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
